// ===== stc_cfg.svh
// constants for the supply trim configuration register bank
`ifndef STC_CFG_SVH
`define STC_CFG_SVH
`define STC_REG_FIRST      8'h03
`define STC_REG_LAST       8'h0C
`define STC_OFS_REVDET     8'h03
`define STC_OFS_CLIM       8'h04
`define STC_OFS_SHOFS      8'h05
`define STC_OFS_SHSLP      8'h06
`define STC_OFS_NVMWP      8'h07
`define STC_OFS_OUTOV      8'h08
`define STC_OFS_NUV        8'h09
`define STC_OFS_NOV        8'h0A
`define STC_OFS_OTP        8'h0B
`define STC_OFS_MAINS      8'h0C
`define STC_BOOT_BASE      16'h8103
`define STC_NUM_REGS       10
`define STC_RD_UNMAPPED    32'h0000_0000
`define STC_BIT_GATE_PEN   3
`define STC_BIT_GATE_RAMP  2
`define STC_BIT_RECOV_HI   1
`define STC_BIT_RECOV_LO   0
`define STC_RECOV_STEP_US  100
`define STC_CLK_MHZ        125
`define STC_RECOV_STEP_CYC (`STC_RECOV_STEP_US * `STC_CLK_MHZ)
`endif

// ===== stc_pkg.sv
// types for the supply trim configuration register bank
package stc_pkg;
  typedef enum logic [2:0] {
    STC_BOOT_REQ  = 3'b001,
    STC_BOOT_WAIT = 3'b010,
    STC_RUN       = 3'b100
  } stc_state_t;

  typedef struct packed {
    logic [1:0] off_sel;
    logic [1:0] on_sel;
    logic       gate_pen;
    logic       gate_ramp;
    logic [1:0] recov_sel;
  } stc_revdet_t;

  typedef struct packed {
    logic [4:0] limit_trim;
    logic [1:0] window_sel;
    logic [6:0] slope_trim;
    logic [7:0] offset_trim;
  } stc_share_t;

  typedef struct packed {
    logic [7:0] outov_trim;
    logic [7:0] nuv_trim;
    logic [7:0] nov_trim;
    logic [3:0] otp_thresh;
    logic       monitor_five_input_soft_otp;
    logic [4:0] mains_thresh;
    logic [2:0] mains_hyst;
  } stc_prot_t;
endpackage : stc_pkg

// ===== stc_regs.sv
// supply trim configuration register bank with boot load and avalon slave
`timescale 1ns/1ps
`include "stc_cfg.svh"
module stc_regs
  import stc_pkg::*;
#(
  parameter int RECOV_STEP_CYC = `STC_RECOV_STEP_CYC
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  output logic [15:0]      o_boot_addr,
  output logic             o_boot_rd,
  input  wire logic [7:0]  i_boot_data,
  input  wire logic        i_boot_valid,
  input  wire logic        i_mains_good,
  input  wire logic        i_pen_request,
  input  wire logic        i_ramp_request,
  input  wire logic        i_outov_trip,
  output logic             o_power_enable_out,
  output logic             o_softstart_run,
  output logic             o_outov_recover_busy,
  output logic             o_boot_done,
  output stc_revdet_t      o_revdet,
  output stc_share_t       o_share,
  output stc_prot_t        o_prot,
  output logic             o_nvm_block_protect_a,
  output logic             o_nvm_block_protect_b,
  output logic             o_nvm_block_protect_c,
  output logic             o_nvm_block_protect_d,
  output logic             o_nvm_boot_protect,
  output logic             o_nvm_factory_protect,
  output logic             o_nvm_block_protect_g
);

  localparam int          NREG        = `STC_NUM_REGS;
  localparam logic [31:0] STEP_RELOAD = 32'(RECOV_STEP_CYC - 1);

  // storage slots, in offset order
  localparam logic [3:0] SLOT_REVDET = 4'h0;
  localparam logic [3:0] SLOT_CLIM   = 4'h1;
  localparam logic [3:0] SLOT_SHOFS  = 4'h2;
  localparam logic [3:0] SLOT_SHSLP  = 4'h3;
  localparam logic [3:0] SLOT_NVMWP  = 4'h4;
  localparam logic [3:0] SLOT_OUTOV  = 4'h5;
  localparam logic [3:0] SLOT_NUV    = 4'h6;
  localparam logic [3:0] SLOT_NOV    = 4'h7;
  localparam logic [3:0] SLOT_OTP    = 4'h8;
  localparam logic [3:0] SLOT_MAINS  = 4'h9;
  localparam logic [3:0] SLOT_LAST   = 4'(NREG - 1);

  typedef struct packed {
    stc_state_t           state;
    logic [3:0]           idx;
    logic [NREG-1:0][7:0] regs;
    logic [31:0]          rdata;
    logic                 wait_n;
    logic                 waitreq;
    logic                 done;
    logic                 power_enable_out;
    logic                 ramp;
    logic [2:0]           steps;
    logic [31:0]          cyc;
    logic                 busy;
    logic [15:0]          boot_addr;
    logic                 boot_rd;
  } stc_st_t;

  // power-up image: bus held off, no output other than waitrequest asserted
  localparam stc_st_t ST_RESET = '{
    state:     STC_BOOT_REQ,
    idx:       4'h0,
    regs:      '0,
    rdata:     32'h0000_0000,
    wait_n:    1'b0,
    waitreq:   1'b1,
    done:      1'b0,
    power_enable_out:       1'b0,
    ramp:      1'b0,
    steps:     3'h0,
    cyc:       32'h0000_0000,
    busy:      1'b0,
    boot_addr: 16'h0000,
    boot_rd:   1'b0
  };

  stc_st_t st_ff;
  stc_st_t nxt_st;

  logic [3:0]      sel;
  logic            hit;
  logic            rd_hit;
  logic            wr_hit;
  logic [7:0]      rd_byte;
  logic [31:0]     rd_word;
  logic            bus_req;
  logic            bus_take;
  logic            wr_commit;
  logic [NREG-1:0] wr_en;
  logic [15:0]     boot_fetch_addr;
  logic [3:0]      boot_next_idx;
  logic            boot_last;
  logic            gate_pen_bit;
  logic            gate_ramp_bit;
  logic [1:0]      recov_code;
  logic            pen_allow;
  logic            ramp_allow;
  logic            recov_step_end;
  logic            recov_last_step;
  logic [2:0]      recov_load;

  // offset decode, one slot per mapped register
  always_comb begin
    sel = SLOT_REVDET;
    hit = 1'b0;
    case (i_avs_address)
      `STC_OFS_REVDET: begin
        sel = SLOT_REVDET;
        hit = 1'b1;
      end
      `STC_OFS_CLIM: begin
        sel = SLOT_CLIM;
        hit = 1'b1;
      end
      `STC_OFS_SHOFS: begin
        sel = SLOT_SHOFS;
        hit = 1'b1;
      end
      `STC_OFS_SHSLP: begin
        sel = SLOT_SHSLP;
        hit = 1'b1;
      end
      `STC_OFS_NVMWP: begin
        sel = SLOT_NVMWP;
        hit = 1'b1;
      end
      `STC_OFS_OUTOV: begin
        sel = SLOT_OUTOV;
        hit = 1'b1;
      end
      `STC_OFS_NUV: begin
        sel = SLOT_NUV;
        hit = 1'b1;
      end
      `STC_OFS_NOV: begin
        sel = SLOT_NOV;
        hit = 1'b1;
      end
      `STC_OFS_OTP: begin
        sel = SLOT_OTP;
        hit = 1'b1;
      end
      `STC_OFS_MAINS: begin
        sel = SLOT_MAINS;
        hit = 1'b1;
      end
      default: begin
        sel = SLOT_REVDET;
        hit = 1'b0;
      end
    endcase
  end

  // read mux over the slots
  always_comb begin
    rd_byte = 8'h00;
    case (sel)
      SLOT_REVDET: rd_byte = st_ff.regs[SLOT_REVDET];
      SLOT_CLIM:   rd_byte = st_ff.regs[SLOT_CLIM];
      SLOT_SHOFS:  rd_byte = st_ff.regs[SLOT_SHOFS];
      SLOT_SHSLP:  rd_byte = st_ff.regs[SLOT_SHSLP];
      SLOT_NVMWP:  rd_byte = st_ff.regs[SLOT_NVMWP];
      SLOT_OUTOV:  rd_byte = st_ff.regs[SLOT_OUTOV];
      SLOT_NUV:    rd_byte = st_ff.regs[SLOT_NUV];
      SLOT_NOV:    rd_byte = st_ff.regs[SLOT_NOV];
      SLOT_OTP:    rd_byte = st_ff.regs[SLOT_OTP];
      SLOT_MAINS:  rd_byte = st_ff.regs[SLOT_MAINS];
      default:     rd_byte = 8'h00;
    endcase
  end

  // qualified hits for each direction
  always_comb begin
    rd_hit = hit & i_avs_read;
    wr_hit = hit & i_avs_write & i_avs_byteenable[0];
  end

  // answer word, unmapped reads give the fixed pattern
  always_comb begin
    rd_word = `STC_RD_UNMAPPED;
    if (rd_hit) begin
      rd_word = {24'h000000, rd_byte};
    end
  end

  // handshake terms; a write lands on the edge that shows waitrequest low
  always_comb begin
    bus_req   = i_avs_read | i_avs_write;
    bus_take  = bus_req & st_ff.done & !st_ff.wait_n;
    wr_commit = wr_hit & st_ff.wait_n;
    wr_en     = '0;
    if (wr_commit) begin
      case (sel)
        SLOT_REVDET: wr_en[SLOT_REVDET] = 1'b1;
        SLOT_CLIM:   wr_en[SLOT_CLIM]   = 1'b1;
        SLOT_SHOFS:  wr_en[SLOT_SHOFS]  = 1'b1;
        SLOT_SHSLP:  wr_en[SLOT_SHSLP]  = 1'b1;
        SLOT_NVMWP:  wr_en[SLOT_NVMWP]  = 1'b1;
        SLOT_OUTOV:  wr_en[SLOT_OUTOV]  = 1'b1;
        SLOT_NUV:    wr_en[SLOT_NUV]    = 1'b1;
        SLOT_NOV:    wr_en[SLOT_NOV]    = 1'b1;
        SLOT_OTP:    wr_en[SLOT_OTP]    = 1'b1;
        SLOT_MAINS:  wr_en[SLOT_MAINS]  = 1'b1;
        default:     wr_en              = '0;
      endcase
    end
  end

  // boot fetch terms
  always_comb begin
    boot_fetch_addr = `STC_BOOT_BASE + {12'h000, st_ff.idx};
    boot_next_idx   = st_ff.idx + 4'h1;
    boot_last       = (st_ff.idx == SLOT_LAST);
  end

  // gating options and recovery code from the calibration slot
  always_comb begin
    gate_pen_bit  = st_ff.regs[SLOT_REVDET][`STC_BIT_GATE_PEN];
    gate_ramp_bit = st_ff.regs[SLOT_REVDET][`STC_BIT_GATE_RAMP];
    recov_code    = st_ff.regs[SLOT_REVDET][`STC_BIT_RECOV_HI:`STC_BIT_RECOV_LO];
    pen_allow     = !gate_pen_bit | i_mains_good;
    ramp_allow    = !gate_ramp_bit | i_mains_good;
  end

  // recovery timer terms: (code+1) steps of one step length
  always_comb begin
    recov_step_end  = (st_ff.cyc == 32'h0000_0000);
    recov_last_step = (st_ff.steps == 3'h1);
    recov_load      = {1'b0, recov_code} + 3'h1;
  end

  always_comb begin
    nxt_st = st_ff;

    // boot sequencer and bus answer
    case (st_ff.state)
      STC_BOOT_REQ: begin
        nxt_st.boot_addr = boot_fetch_addr;
        nxt_st.boot_rd   = 1'b1;
        nxt_st.state     = STC_BOOT_WAIT;
      end
      STC_BOOT_WAIT: begin
        nxt_st.boot_rd = 1'b0;
        if (i_boot_valid) begin
          nxt_st.regs[st_ff.idx] = i_boot_data;
          if (boot_last) begin
            nxt_st.state = STC_RUN;
          end else begin
            nxt_st.idx   = boot_next_idx;
            nxt_st.state = STC_BOOT_REQ;
          end
        end
      end
      STC_RUN: begin
        // one wait cycle per access, answer stands for one edge
        if (bus_take) begin
          nxt_st.wait_n = 1'b1;
          nxt_st.rdata  = rd_word;
        end else begin
          nxt_st.wait_n = 1'b0;
        end
        // register writes
        for (int i = 0; i < NREG; i++) begin
          if (wr_en[i]) begin
            nxt_st.regs[i] = i_avs_writedata[7:0];
          end
        end
      end
      default: begin
        nxt_st.state = STC_BOOT_REQ;
      end
    endcase
    nxt_st.waitreq = !nxt_st.wait_n;
    nxt_st.done    = (nxt_st.state == STC_RUN);

    // enables follow their requests one cycle late, only after boot
    nxt_st.power_enable_out  = i_pen_request & pen_allow & st_ff.done;
    nxt_st.ramp = i_ramp_request & ramp_allow & st_ff.done;

    // recovery timer, held loaded while the trip stands
    if (i_outov_trip) begin
      nxt_st.busy  = 1'b1;
      nxt_st.steps = recov_load;
      nxt_st.cyc   = STEP_RELOAD;
    end else if (st_ff.busy) begin
      if (!recov_step_end) begin
        nxt_st.cyc = st_ff.cyc - 32'h0000_0001;
      end else if (recov_last_step) begin
        nxt_st.busy = 1'b0;
      end else begin
        nxt_st.steps = st_ff.steps - 3'h1;
        nxt_st.cyc   = STEP_RELOAD;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      st_ff <= ST_RESET;
    end else if (i_ce) begin
      st_ff <= nxt_st;
    end
  end

  // field outputs, all taken straight from register flip-flops
  always_comb begin
    o_revdet.off_sel   = st_ff.regs[0][7:6];
    o_revdet.on_sel    = st_ff.regs[0][5:4];
    o_revdet.gate_pen  = st_ff.regs[0][3];
    o_revdet.gate_ramp = st_ff.regs[0][2];
    o_revdet.recov_sel = st_ff.regs[0][1:0];
    o_share.limit_trim  = st_ff.regs[1][7:3];
    o_share.window_sel  = st_ff.regs[1][1:0];
    o_share.offset_trim = st_ff.regs[2];
    o_share.slope_trim  = st_ff.regs[3][7:1];
    o_prot.outov_trim    = st_ff.regs[5];
    o_prot.nuv_trim      = st_ff.regs[6];
    o_prot.nov_trim      = st_ff.regs[7];
    o_prot.otp_thresh    = st_ff.regs[8][7:4];
    o_prot.monitor_five_input_soft_otp = st_ff.regs[8][0];
    o_prot.mains_thresh  = st_ff.regs[9][7:3];
    o_prot.mains_hyst    = st_ff.regs[9][2:0];
  end

  assign o_nvm_block_protect_a = st_ff.regs[4][0];
  assign o_nvm_block_protect_b = st_ff.regs[4][1];
  assign o_nvm_block_protect_c = st_ff.regs[4][2];
  assign o_nvm_block_protect_d = st_ff.regs[4][3];
  assign o_nvm_boot_protect    = st_ff.regs[4][4];
  assign o_nvm_factory_protect = st_ff.regs[4][5];
  assign o_nvm_block_protect_g = st_ff.regs[4][6];

  assign o_avs_readdata       = st_ff.rdata;
  assign o_avs_waitrequest    = st_ff.waitreq;
  assign o_boot_addr          = st_ff.boot_addr;
  assign o_boot_rd            = st_ff.boot_rd;
  assign o_boot_done          = st_ff.done;
  assign o_power_enable_out   = st_ff.power_enable_out;
  assign o_softstart_run      = st_ff.ramp;
  assign o_outov_recover_busy = st_ff.busy;

endmodule : stc_regs

// ===== stc_regs_monitor.sv
// assertion checker for the supply trim register bank
`timescale 1ns/1ps
module stc_regs_monitor
  import stc_pkg::*;
#(
  parameter int RECOV_STEP_CYC = 4
) (
  input wire logic        i_clk_sys,
  input wire logic        i_rst_n,
  input wire logic        i_ce,
  input wire logic [7:0]  i_avs_address,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0]  i_avs_byteenable,
  input wire logic        o_avs_waitrequest,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_boot_rd,
  input wire logic [15:0] o_boot_addr,
  input wire logic        o_boot_done,
  input wire logic        i_mains_good,
  input wire logic        i_pen_request,
  input wire logic        i_ramp_request,
  input wire logic        o_power_enable_out,
  input wire logic        o_softstart_run,
  input wire stc_revdet_t o_revdet,
  input wire logic        i_outov_trip,
  input wire logic        o_outov_recover_busy
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  property p_pen; $past(o_boot_done && i_ce) |-> o_power_enable_out ==
    $past(i_pen_request && (!o_revdet.gate_pen || i_mains_good)); endproperty
  a_pen: assert property (p_pen) else $error("power enable gating wrong");
  property p_ramp; $past(o_boot_done && i_ce) |-> o_softstart_run ==
    $past(i_ramp_request && (!o_revdet.gate_ramp || i_mains_good)); endproperty
  a_ramp: assert property (p_ramp) else $error("soft-start gating wrong");
  property p_wr; i_avs_write && !o_avs_waitrequest && i_avs_address == 8'h03 &&
    i_avs_byteenable[0] |=> o_revdet == $past(i_avs_writedata[7:0]); endproperty
  a_wr: assert property (p_wr) else $error("calibration fields not written");
  property p_ans; !o_avs_waitrequest |=> o_avs_waitrequest; endproperty
  a_ans: assert property (p_ans) else $error("answer longer than one cycle");
  property p_hi; !o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h000000; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits not zero");
  property p_bw; !o_boot_done |-> o_avs_waitrequest; endproperty
  a_bw: assert property (p_bw) else $error("bus answered during boot");
  property p_ba; o_boot_rd |-> o_boot_addr >= 16'h8103 && o_boot_addr <= 16'h810C; endproperty
  a_ba: assert property (p_ba) else $error("boot address out of range");
  property p_rc; $fell(i_outov_trip) |-> o_outov_recover_busy [*4] ##[1:20]
    !o_outov_recover_busy; endproperty
  a_rc: assert property (p_rc) else $error("recovery delay wrong");
endmodule : stc_regs_monitor
bind stc_regs stc_regs_monitor #(.RECOV_STEP_CYC(RECOV_STEP_CYC)) u_mon (.*);

// ===== stc_regs_tb_top.sv
// self-checking testbench for the supply trim register bank
`timescale 1ns/1ps
module stc_regs_tb_top
  import stc_pkg::*;
;
  logic i_clk_sys = 1'b0, i_rst_n = 1'b0, i_ce = 1'b1, i_avs_read = 1'b0, i_avs_write = 1'b0;
  logic i_boot_valid = 1'b0, i_mains_good = 1'b0, i_pen_request = 1'b0;
  logic i_ramp_request = 1'b0, i_outov_trip = 1'b0;
  logic [7:0] i_avs_address = 8'h00, i_boot_data = 8'h00;
  logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata;
  logic [3:0] i_avs_byteenable = 4'h0;
  logic [15:0] o_boot_addr;
  logic o_avs_waitrequest, o_boot_rd, o_power_enable_out, o_softstart_run;
  logic o_outov_recover_busy, o_boot_done;
  logic [6:0] nvm;
  stc_revdet_t o_revdet;
  stc_share_t o_share;
  stc_prot_t o_prot;
  int n_fail = 0, samples_checked = 0;
  stc_regs #(.RECOV_STEP_CYC(4)) dut (.*, .o_nvm_block_protect_a(nvm[0]),
    .o_nvm_block_protect_b(nvm[1]), .o_nvm_block_protect_c(nvm[2]),
    .o_nvm_block_protect_d(nvm[3]), .o_nvm_boot_protect(nvm[4]),
    .o_nvm_factory_protect(nvm[5]), .o_nvm_block_protect_g(nvm[6]));
  always #4 i_clk_sys = ~i_clk_sys;
  // boot store answers one cycle after each fetch
  always @(posedge i_clk_sys) begin
    i_boot_valid <= o_boot_rd;
    i_boot_data <= o_boot_addr[7:0] ^ 8'hA5;
  end
  task automatic cmp(input string w, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", w, e, g);
    end
  endtask : cmp
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    @(posedge i_clk_sys);
    i_avs_address <= a;
    i_avs_write <= wr;
    i_avs_read <= !wr;
    i_avs_writedata <= {24'h000000, d};
    i_avs_byteenable <= be;
    do @(posedge i_clk_sys); while (o_avs_waitrequest !== 1'b0);
    q = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
    logic [31:0] q;
    bus(1'b1, a, d, be, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, 4'hF, q);
    cmp("readback", {24'h000000, e}, q);
  endtask : rd
  task automatic test_boot;
    logic [7:0] b [3:12];
    for (int i = 0; i < 400 && o_boot_done !== 1'b1; i++) @(posedge i_clk_sys);
    for (int o = 3; o <= 12; o++) b[o] = o[7:0] ^ 8'hA5;
    for (int o = 3; o <= 12; o++) rd(o[7:0], b[o]);
    cmp("revdet", b[3], o_revdet);
    cmp("share", {b[4][7:3], b[4][1:0], b[6][7:1], b[5]}, o_share);
    cmp("nvm", b[7][6:0], nvm);
    cmp("prot", 1, o_prot === {b[8], b[9], b[10], b[11][7:4], b[11][0], b[12]});
    $display("test boot done");
  endtask : test_boot
  task automatic test_rw;
    for (int o = 2; o <= 13; o++) begin
      wr(o[7:0], o[7:0] ^ 8'h5A, 4'h1);
      wr(o[7:0], 8'h00, 4'h0);
      rd(o[7:0], (o == 2 || o == 13) ? 8'h00 : o[7:0] ^ 8'h5A);
    end
    cmp("slope", 8'h5C >> 1, o_share.slope_trim);
    cmp("otp", 5'h0B, {o_prot.otp_thresh, o_prot.monitor_five_input_soft_otp});
    $display("test rw done");
  endtask : test_rw
  task automatic test_gate;
    for (int g = 0; g < 8; g++) begin
      wr(8'h03, {4'h0, g[2:1], 2'b00}, 4'h1);
      i_pen_request <= 1'b1;
      i_ramp_request <= 1'b1;
      i_mains_good <= g[0];
      repeat (3) @(posedge i_clk_sys);
      cmp("pen", !g[2] || g[0], o_power_enable_out);
      cmp("ramp", !g[1] || g[0], o_softstart_run);
    end
    i_ce <= 1'b0;
    i_pen_request <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    cmp("pen frozen", 1, o_power_enable_out);
    i_ce <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    cmp("pen released", 0, o_power_enable_out);
    $display("test gate done");
  endtask : test_gate
  task automatic test_recov;
    int n;
    for (int s = 0; s < 4; s++) begin
      wr(8'h03, {6'h00, s[1:0]}, 4'h1);
      i_outov_trip <= 1'b1;
      repeat (3) @(posedge i_clk_sys);
      i_outov_trip <= 1'b0;
      n = 0;
      do begin
        @(posedge i_clk_sys);
        n++;
      end while (o_outov_recover_busy === 1'b1 && n < 100);
      cmp("recov", 1, n > (s + 1) * 4 && n <= (s + 1) * 4 + 3);
    end
    $display("test recov done");
  endtask : test_recov
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    #200000;
    n_fail++;
    tally_and_finish;
  end
  initial begin
    repeat (20) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    test_boot;
    test_rw;
    test_gate;
    test_recov;
    tally_and_finish;
  end
endmodule : stc_regs_tb_top
